// File: hdl/delay_counter.sv
// loadable down-counter giving a one-cycle done pulse
`timescale 1ns/100ps
`default_nettype none
module delay_counter #(
    parameter int CNT_W = 32
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             clear,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] load_value,
    output var  logic             busy,
    output var  logic             done
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             busy;
        logic             done;
    } cnt_state_t;

    cnt_state_t state_reg;
    cnt_state_t state_next;

    always_comb begin
        state_next      = state_reg;
        state_next.done = 1'b0;
        if (clear) begin
            state_next.busy  = 1'b0;
            state_next.count = '0;
        end else if (start) begin
            state_next.busy  = 1'b1;
            state_next.count = load_value;
        end else if (state_reg.busy) begin
            if (state_reg.count <= CNT_W'(1)) begin
                state_next.busy = 1'b0;
                state_next.done = 1'b1;
                state_next.count = '0;
            end else begin
                state_next.count = state_reg.count - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign busy = state_reg.busy;
    assign done = state_reg.done;
endmodule // delay_counter
`default_nettype wire

// File: hdl/edge_detect.sv
// rise and fall detector for synchronous pin levels, combinational outputs from a registered previous level
`timescale 1ns/100ps
`default_nettype none
module edge_detect (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic level_in,
    input  wire logic reset_level,
    output var  logic rise,
    output var  logic fall
);
    typedef struct packed {
        logic prev;
        logic primed;
    } edge_state_t;

    edge_state_t state_reg;
    edge_state_t state_next;

    always_comb begin
        state_next.prev   = level_in;
        state_next.primed = 1'b1;
    end

    // no edge is reported on the first cycle after reset
    assign rise = state_reg.primed & level_in & ~state_reg.prev;
    assign fall = state_reg.primed & ~level_in & state_reg.prev;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule // edge_detect
`default_nettype wire

// File: hdl/hot_swap_fault_sequencer.sv
// gate sequencing, power-good chain and fault retry logic of a hot-swap controller
// Overview of operation
// (RQ1) low drain-source and high gate latch power-good and start three delays
// (RQ2) after two base delays drive first power-good low
// (RQ3) after two more base delays drive second power-good low
// (RQ4) module-good must go low in four base delays, else gate off, power-bad
// (RQ5) every turn-off except overvoltage resets both power-good outputs
// (RQ6) listed conditions turn gate off and discharge soft-start and timer
// (RQ7) on, enable and supply lockout turn-offs restart automatically when cleared
// (RQ8) per-fault retry bit: zero latches off, one retries after the fault clears
// (RQ9) retry delay one base for undervoltage, power-bad; four overcurrent; none overvoltage
// (RQ10) overcurrent retry reset value is a build parameter
// (RQ11) status mirrors enable pin; change fault set on any enable edge
// (RQ12) on pin rise sets gate-on bit, fall clears it
// (RQ13) enable falling edge copies high on pin into gate-on bit after delay
// (RQ14) enable-change fault and gate-on bit writable, cleared in logic lockout
// (RQ15) gate status is AND of enabled, gate-on bit and no faults; drives gate
// (RQ16) sense above 50mV starts 530us breaker timer
// (RQ17) breaker expiry: gate off, discharge, reset power-good, set overcurrent bits
// (RQ18) overcurrent present clears when off; restart four base delays after retry or clear
// (RQ19) overcurrent cooling interval is never cut short or restarted
// (RQ20) fast sense comparator pulls gate low at once
// (RQ21) overvoltage turns gate off, sets overvoltage bits, discharges soft-start
// (RQ22) overvoltage clearing allows gate on at once unless retry bit cleared
// (RQ23) base delay scales with timer capacitor; double and quadruple derived
// (RQ24) base delay is a cycle count; multiples are counter terminal values
`timescale 1ns/100ps
`default_nettype none
module hot_swap_fault_sequencer #(
    parameter int         CNT_W       = hot_swap_pkg::CNT_W,
    parameter int         BASE_CYCLES = hot_swap_pkg::BASE_DELAY_CYCLES,
    parameter int         BRK_CYCLES  = hot_swap_pkg::BREAKER_CYCLES,
    parameter int         EN_CYCLES   = hot_swap_pkg::EN_LATCH_CYCLES,
    parameter logic       OC_RETRY_RST = hot_swap_pkg::OC_RETRY_RST_LATCH
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic on_pin,
    input  wire logic enable_pin_n,
    input  wire logic vds_low,
    input  wire logic gate_high,
    input  wire logic module_good_in_n,
    input  wire logic undervolt_low_in,
    input  wire logic undervolt_high_in,
    input  wire logic high_supply_in,
    input  wire logic vin_lockout,
    input  wire logic internal_logic_supply_lockout,
    input  wire logic sense_over_limit,
    input  wire logic sense_fast_trip,
    input  wire logic wr_fet_on_ctrl,
    input  wire logic wr_fet_on_value,
    input  wire logic wr_enable_change_fault,
    input  wire logic wr_enable_change_value,
    input  wire logic wr_fault_clear,
    input  wire logic [3:0] wr_fault_clear_mask,
    input  wire logic wr_retry,
    input  wire logic [3:0] wr_retry_value,
    output var  logic gate_on_cmd,
    output var  logic fast_pulldown,
    output var  logic discharge_caps,
    output var  logic first_power_good_n,
    output var  logic second_power_good_io_o,
    output var  logic second_power_good_io_oe,
    output var  logic gate_on_status,
    output var  logic enable_pin_state,
    output var  logic enable_change_fault,
    output var  logic fet_on_ctrl,
    output var  logic overcurrent_present,
    output var  logic overcurrent_fault,
    output var  logic overvoltage_present,
    output var  logic overvoltage_fault,
    output var  logic undervoltage_fault,
    output var  logic power_bad_fault,
    output var  logic [3:0] retry_en
);
    // retry_en bit order: 0 overvoltage, 1 undervoltage, 2 overcurrent, 3 power-bad
    localparam logic [CNT_W-1:0] T1 = CNT_W'(BASE_CYCLES);
    localparam logic [CNT_W-1:0] T2 = CNT_W'(2 * BASE_CYCLES);
    localparam logic [CNT_W-1:0] T4 = CNT_W'(4 * BASE_CYCLES);

    typedef struct packed {
        hot_swap_pkg::seq_state_t seq;
        logic [CNT_W-1:0] brk_cnt;
        logic [CNT_W-1:0] en_cnt;
        logic       en_pending;
        logic       oc_cool;
        logic       retry_wait;
        logic       ov_was;
        logic       uv_was;
        logic       gate;
        logic       fast;
        logic       dis;
        logic       pg1_n;
        logic       pg2_n;
        logic       gstat;
        logic       en_state;
        logic       en_fault;
        logic       fet_on;
        logic       oc_pres;
        logic       oc_flt;
        logic       ov_pres;
        logic       ov_flt;
        logic       uv_flt;
        logic       pb_flt;
        logic [3:0] retry;
    } seq_regs_t;

    seq_regs_t st_reg;
    seq_regs_t st_next;

    logic on_rise, on_fall, en_rise, en_fall;
    logic tmr_start, tmr_clear, tmr_busy, tmr_done;
    logic [CNT_W-1:0] tmr_load;

    edge_detect u_on_edge (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .level_in    (on_pin),
        .reset_level (1'b0),
        .rise        (on_rise),
        .fall        (on_fall)
    );

    edge_detect u_en_edge (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .level_in    (enable_pin_n),
        .reset_level (1'b1),
        .rise        (en_rise),
        .fall        (en_fall)
    );

    delay_counter #(.CNT_W(CNT_W)) u_timer (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .clear      (tmr_clear),
        .start      (tmr_start),
        .load_value (tmr_load),
        .busy       (tmr_busy),
        .done       (tmr_done)
    );

    logic uv_now, lockout, blocked, faulted, others, ov_hold;

    always_comb begin
        uv_now  = ~undervolt_low_in & ~undervolt_high_in;
        lockout = vin_lockout | internal_logic_supply_lockout;
        st_next = st_reg;
        tmr_start = 1'b0;
        tmr_clear = 1'b0;
        tmr_load  = T1;
        st_next.fast = sense_fast_trip; // [RQ20]
        st_next.en_state = enable_pin_n; // [RQ11]
        // event set wins over a software write in the same cycle
        if (wr_enable_change_fault) st_next.en_fault = wr_enable_change_value; // [RQ14]
        if (en_rise | en_fall) st_next.en_fault = 1'b1; // [RQ11]
        if (wr_fet_on_ctrl) st_next.fet_on = wr_fet_on_value; // [RQ14]
        if (on_rise) st_next.fet_on = 1'b1; // [RQ12]
        if (on_fall) st_next.fet_on = 1'b0; // [RQ12]
        // enable falling edge arms a delayed copy of the on pin
        if (en_fall) begin
            st_next.en_pending = 1'b1;
            st_next.en_cnt     = CNT_W'(EN_CYCLES);
        end else if (st_reg.en_pending) begin
            if (st_reg.en_cnt <= CNT_W'(1)) begin
                st_next.en_pending = 1'b0;
                if (on_pin) st_next.fet_on = 1'b1; // [RQ13]
            end else begin
                st_next.en_cnt = st_reg.en_cnt - CNT_W'(1);
            end
        end
        if (wr_retry) st_next.retry = wr_retry_value;
        if (wr_fault_clear) begin
            if (wr_fault_clear_mask[0]) st_next.ov_flt = 1'b0;
            if (wr_fault_clear_mask[1]) st_next.uv_flt = 1'b0;
            if (wr_fault_clear_mask[2]) st_next.oc_flt = 1'b0;
            if (wr_fault_clear_mask[3]) st_next.pb_flt = 1'b0;
        end
        // overvoltage: immediate off, power-good untouched
        st_next.ov_pres = high_supply_in; // [RQ21]
        st_next.ov_was  = high_supply_in;
        if (high_supply_in) st_next.ov_flt = 1'b1; // [RQ21]
        st_next.uv_was = uv_now;
        if (uv_now) st_next.uv_flt = 1'b1;
        // circuit breaker timer
        if (sense_over_limit && st_reg.gate) begin
            if (st_reg.brk_cnt >= CNT_W'(BRK_CYCLES - 1)) begin // [RQ16]
                st_next.brk_cnt = '0; // [RQ17]
                st_next.oc_pres = 1'b1; // [RQ17]
                st_next.oc_flt  = 1'b1; // [RQ17]
            end else begin
                st_next.brk_cnt = st_reg.brk_cnt + CNT_W'(1); // [RQ16]
            end
        end else begin
            st_next.brk_cnt = '0;
        end
        if (!st_reg.gate && st_reg.oc_pres) st_next.oc_pres = 1'b0; // [RQ18]
        // latched faults block the gate when retry is disabled
        faulted = (st_next.oc_flt & ~st_reg.retry[2]) | (st_next.uv_flt & ~st_reg.retry[1])
                | (st_next.pb_flt & ~st_reg.retry[3]) | (st_next.ov_flt & ~st_reg.retry[0]); // [RQ8]
        // overvoltage with retry set releases at once, no delay [RQ22]
        others  = ~st_next.fet_on | enable_pin_n | uv_now | lockout
                | st_next.oc_pres | faulted | st_reg.oc_cool;
        blocked = others | high_supply_in; // [RQ6] [RQ7]
        ov_hold = ~others & high_supply_in & (st_reg.seq >= hot_swap_pkg::SEQ_WAIT_PG);
        // overcurrent cooling runs to completion regardless of other faults
        if (st_reg.oc_cool) begin
            if (tmr_done) begin
                st_next.oc_cool = 1'b0; // [RQ19]
                st_next.seq     = hot_swap_pkg::SEQ_WAIT_PG; // [RQ18]
            end
        end else if (st_reg.oc_pres && !st_reg.gate) begin
            st_next.oc_cool = 1'b1; // [RQ18]
            tmr_start = 1'b1;
            tmr_load  = T4; // [RQ9]
            st_next.seq = hot_swap_pkg::SEQ_OFF;
        end
        if (!st_reg.oc_cool && !(st_reg.oc_pres && !st_reg.gate)) begin
            if (blocked && !ov_hold) begin
                tmr_clear = 1'b1; // [RQ6]
                st_next.seq = hot_swap_pkg::SEQ_OFF;
                // retry wait flag is set only by an undervoltage turn-off while the gate is on
                st_next.retry_wait = st_reg.retry_wait | (st_reg.gate & uv_now);
            end else begin
                case (st_reg.seq)
                    hot_swap_pkg::SEQ_OFF: begin
                        tmr_start = 1'b1;
                        tmr_load  = T1; // [RQ9] [RQ24]
                        st_next.seq = hot_swap_pkg::SEQ_STARTUP;
                        st_next.retry_wait = 1'b0;
                    end
                    hot_swap_pkg::SEQ_STARTUP: begin
                        if (tmr_done) st_next.seq = hot_swap_pkg::SEQ_WAIT_PG;
                    end
                    hot_swap_pkg::SEQ_WAIT_PG: begin
                        if (vds_low && gate_high) begin // [RQ1]
                            tmr_start = 1'b1;
                            tmr_load  = T2; // [RQ23]
                            st_next.seq = hot_swap_pkg::SEQ_PG1;
                        end
                    end
                    hot_swap_pkg::SEQ_PG1: begin
                        if (tmr_done) begin
                            st_next.pg1_n = 1'b0; // [RQ2]
                            tmr_start = 1'b1;
                            tmr_load  = T2;
                            st_next.seq = hot_swap_pkg::SEQ_PG2;
                        end
                    end
                    hot_swap_pkg::SEQ_PG2: begin
                        if (tmr_done) begin
                            st_next.pg2_n = 1'b0; // [RQ3]
                            tmr_start = 1'b1;
                            tmr_load  = T4;
                            st_next.seq = hot_swap_pkg::SEQ_CHECK;
                        end
                    end
                    hot_swap_pkg::SEQ_CHECK: begin
                        if (tmr_done) begin
                            if (module_good_in_n) begin
                                st_next.pb_flt = 1'b1; // [RQ4]
                                st_next.seq = hot_swap_pkg::SEQ_OFF;
                            end else begin
                                st_next.seq = hot_swap_pkg::SEQ_GOOD;
                            end
                        end
                    end
                    hot_swap_pkg::SEQ_GOOD: begin
                        st_next.seq = hot_swap_pkg::SEQ_GOOD;
                    end
                    default: st_next.seq = hot_swap_pkg::SEQ_OFF;
                endcase
            end
        end
        // gate is on from startup expiry until any blocking cause
        st_next.gstat = ~blocked & ~enable_pin_n & st_next.fet_on
                      & (st_next.seq >= hot_swap_pkg::SEQ_WAIT_PG) & ~st_next.oc_cool; // [RQ15]
        st_next.gate = st_next.gstat & ~sense_fast_trip; // [RQ20]
        st_next.dis  = ~st_next.gstat; // [RQ6] [RQ21]
        // overvoltage alone keeps the power-good outputs [RQ5]
        if (!st_next.gstat && !(high_supply_in && !st_next.oc_pres && !st_next.pb_flt)) begin
            st_next.pg1_n = 1'b1; // [RQ5]
            st_next.pg2_n = 1'b1; // [RQ5]
        end
        if (internal_logic_supply_lockout) begin
            st_next.en_fault = 1'b0; // [RQ14]
            st_next.fet_on   = 1'b0; // [RQ14]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg       <= '0;
            st_reg.pg1_n <= 1'b1;
            st_reg.pg2_n <= 1'b1;
            st_reg.dis   <= 1'b1;
            st_reg.en_state <= 1'b1;
            st_reg.retry <= {hot_swap_pkg::PB_RETRY_RST, OC_RETRY_RST, // [RQ10]
                             hot_swap_pkg::UV_RETRY_RST, hot_swap_pkg::OV_RETRY_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign gate_on_cmd             = st_reg.gate;
    assign fast_pulldown           = st_reg.fast;
    assign discharge_caps          = st_reg.dis;
    assign first_power_good_n      = st_reg.pg1_n;
    assign second_power_good_io_o  = st_reg.pg2_n;
    assign second_power_good_io_oe = ~st_reg.pg2_n;
    assign gate_on_status          = st_reg.gstat;
    assign enable_pin_state        = st_reg.en_state;
    assign enable_change_fault     = st_reg.en_fault;
    assign fet_on_ctrl             = st_reg.fet_on;
    assign overcurrent_present     = st_reg.oc_pres;
    assign overcurrent_fault       = st_reg.oc_flt;
    assign overvoltage_present     = st_reg.ov_pres;
    assign overvoltage_fault       = st_reg.ov_flt;
    assign undervoltage_fault      = st_reg.uv_flt;
    assign power_bad_fault         = st_reg.pb_flt;
    assign retry_en                = st_reg.retry;

    chk_pg_before_second: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3]
        !second_power_good_io_o |-> !first_power_good_n)
        else $error("second power-good low before first");
    chk_gate_needs_on: assert property (@(posedge clk) disable iff (sys_rst) // [RQ15]
        gate_on_status |-> fet_on_ctrl && !enable_pin_state)
        else $error("gate on without on bit or enable");
    chk_ov_gate_off: assert property (@(posedge clk) disable iff (sys_rst) // [RQ21]
        high_supply_in |=> !gate_on_cmd && overvoltage_fault)
        else $error("overvoltage did not turn gate off");
    chk_fast_trip: assert property (@(posedge clk) disable iff (sys_rst) // [RQ20]
        sense_fast_trip |=> !gate_on_cmd)
        else $error("fast trip did not pull gate low");
    chk_en_change: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
        $changed(enable_pin_n) && !internal_logic_supply_lockout |=> ##1 enable_change_fault)
        else $error("enable change not flagged");
    chk_lockout_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RQ14]
        internal_logic_supply_lockout |=> !fet_on_ctrl && !enable_change_fault)
        else $error("lockout did not clear control bits");
    chk_on_rise: assert property (@(posedge clk) disable iff (sys_rst) // [RQ12]
        $rose(on_pin) && !internal_logic_supply_lockout |=> fet_on_ctrl)
        else $error("on rise did not set gate-on bit");
    chk_oc_latch: assert property (@(posedge clk) disable iff (sys_rst) // [RQ17]
        $rose(overcurrent_present) |-> overcurrent_fault && !gate_on_cmd ##1 !gate_on_status)
        else $error("overcurrent did not latch fault");
    cov_pg1: cover property (@(posedge clk) disable iff (sys_rst) $fell(first_power_good_n));
    cov_power_bad_fault: cover property (@(posedge clk) disable iff (sys_rst) $rose(power_bad_fault));
    cov_oc: cover property (@(posedge clk) disable iff (sys_rst) $rose(overcurrent_fault));
endmodule // hot_swap_fault_sequencer
`default_nettype wire

// File: hdl/hot_swap_pkg.sv
// constants and types shared by the hot-swap sequencer
package hot_swap_pkg;
    localparam int  CLK_HZ            = 40_000_000;
    // base start-up delay per 1 uF of timing capacitor
    localparam int  BASE_DELAY_MS_PER_UF = 256;
    localparam int  BASE_DELAY_CYCLES = BASE_DELAY_MS_PER_UF * (CLK_HZ / 1000);
    localparam int  BREAKER_TIME_US   = 530;
    localparam int  BREAKER_CYCLES    = (BREAKER_TIME_US * (CLK_HZ / 1000)) / 1000;
    localparam int  EN_LATCH_TIME_US  = 10;
    localparam int  EN_LATCH_CYCLES   = (EN_LATCH_TIME_US * (CLK_HZ / 1000)) / 1000;
    localparam int  CNT_W             = 32;
    localparam logic OC_RETRY_RST_LATCH = 1'b0;
    localparam logic UV_RETRY_RST     = 1'b1;
    localparam logic OV_RETRY_RST     = 1'b1;
    localparam logic PB_RETRY_RST     = 1'b0;

    typedef enum logic [2:0] {
        SEQ_OFF     = 3'b000,
        SEQ_STARTUP = 3'b001,
        SEQ_WAIT_PG = 3'b010,
        SEQ_PG1     = 3'b011,
        SEQ_PG2     = 3'b100,
        SEQ_CHECK   = 3'b101,
        SEQ_GOOD    = 3'b110
    } seq_state_t;
endpackage : hot_swap_pkg

// File: verification/downstream_model.sv
// behavioural downstream modules and their supply monitor
`timescale 1ns/100ps
`default_nettype none
module downstream_model (
    input  wire logic clk,
    input  wire logic gate_on_cmd,
    input  wire logic first_power_good_n,
    input  wire logic second_power_good_n,
    input  wire logic good,
    output var  logic vds_low,
    output var  logic gate_high,
    output var  logic module_good_in_n
);
    logic [1:0] gate_d = 2'h0;
    int         cnt    = 0;
    assign gate_high = gate_d[0];
    assign vds_low   = gate_d[1];
    always @(posedge clk) begin
        gate_d <= {gate_d[0], gate_on_cmd};
        cnt    <= (first_power_good_n || second_power_good_n) ? 0 : cnt + 1;
    end
    // a failing module never answers, so the check window must expire
    assign module_good_in_n = !(good && cnt >= 5);
endmodule // downstream_model
`default_nettype wire

// File: verification/hot_swap_fault_sequencer_tb.sv
// self-checking bench for the hot-swap fault sequencer
`timescale 1ns/100ps
`default_nettype none
module hot_swap_fault_sequencer_tb;
    localparam int B  = 20;
    localparam int BR = 10;
    logic clk, sys_rst = 1'h1, on_pin = 1'h0, enable_pin_n = 1'h0, high_supply_in = 1'h0;
    logic vin_lockout = 1'h0, sense_over_limit = 1'h0, sense_fast_trip = 1'h0, good = 1'h1;
    logic uv_ok = 1'h1, int_lock = 1'h0, undervoltage_fault;
    logic wr_fet_on_ctrl = 1'h0, wr_fet_on_value = 1'h0, wr_fault_clear = 1'h0, wr_retry = 1'h0;
    logic [3:0] wr_fault_clear_mask = 4'h0, wr_retry_value = 4'h0, retry_en, r;
    logic vds_low, gate_high, module_good_in_n, gate_on_cmd, fast_pulldown, first_power_good_n;
    logic second_power_good_io_o, second_power_good_io_oe, enable_pin_state, enable_change_fault;
    logic fet_on_ctrl, overcurrent_fault, overvoltage_present, overvoltage_fault, power_bad_fault;
    logic pg2;
    logic [2:0] obs, prev;
    logic qv[3][$];
    int ql[3][$], qh[3][$];
    int num_errors = 0, n_compared = 0, cyc = 0, seed = 99;
    // second power-good is open drain with a pull-up
    assign pg2 = second_power_good_io_oe ? second_power_good_io_o : 1'h1;
    assign obs = {pg2, first_power_good_n, gate_on_cmd};
    hot_swap_fault_sequencer #(.BASE_CYCLES(B), .BRK_CYCLES(BR), .EN_CYCLES(3),
        .OC_RETRY_RST(1'h1)) i_hot_swap_fault_sequencer (
        .clk, .sys_rst, .on_pin, .enable_pin_n, .vds_low, .gate_high, .module_good_in_n,
        .undervolt_low_in(uv_ok), .undervolt_high_in(uv_ok), .high_supply_in, .vin_lockout,
        .internal_logic_supply_lockout(int_lock), .sense_over_limit, .sense_fast_trip,
        .wr_fet_on_ctrl, .wr_fet_on_value, .wr_enable_change_fault(1'h0),
        .wr_enable_change_value(1'h0), .wr_fault_clear, .wr_fault_clear_mask, .wr_retry,
        .wr_retry_value, .gate_on_cmd, .fast_pulldown, .discharge_caps(), .first_power_good_n,
        .second_power_good_io_o, .second_power_good_io_oe, .gate_on_status(),
        .enable_pin_state, .enable_change_fault, .fet_on_ctrl, .overcurrent_present(),
        .overcurrent_fault, .overvoltage_present, .overvoltage_fault,
        .undervoltage_fault, .power_bad_fault, .retry_en);
    downstream_model i_downstream_model (.clk, .gate_on_cmd, .first_power_good_n,
        .second_power_good_n(pg2), .good, .vds_low, .gate_high, .module_good_in_n);
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    task automatic fail(input string m);
        num_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic cmp(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) fail("status flag wrong");
    endtask
    task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) fail("retry bits wrong");
    endtask
    task automatic note(input int s, input logic v, input int lo, input int hi);
        qv[s].push_back(v);
        ql[s].push_back(cyc + lo);
        qh[s].push_back(cyc + hi);
    endtask
    task automatic take(input int s, input logic v);
        int lo, hi;
        n_compared++;
        if (qv[s].size() == 0) fail("unexpected output change");
        else begin
            lo = ql[s].pop_front();
            hi = qh[s].pop_front();
            if (qv[s].pop_front() !== v || cyc < lo || cyc > hi) fail("change wrong or late");
        end
    endtask
    always @(posedge clk) begin
        cyc  <= cyc + 1;
        prev <= obs;
        if (!sys_rst) for (int s = 0; s < 3; s++) if (obs[s] !== prev[s]) take(s, obs[s]);
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_gate(input logic v);
        for (int i = 0; i < 400 && gate_on_cmd !== v; i++) @(negedge clk);
    endtask
    task automatic off(input int lo, input int hi, input logic pg);
        note(0, 1'h0, lo, hi);
        if (pg) begin
            note(1, 1'h1, lo, hi);
            note(2, 1'h1, lo, hi);
        end
    endtask
    task automatic chain(input logic bad);
        note(1, 1'h0, 2 * B, 2 * B + 8);
        note(2, 1'h0, 4 * B, 4 * B + 12);
        if (bad) off(8 * B, 8 * B + 20, 1'h1);
        tick(8 * B + 24);
    endtask
    task automatic complete_run();
        for (int s = 0; s < 3; s++) if (qv[s].size() != 0) fail("expected change missing");
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        fail("watchdog expired");
        complete_run();
    end
    initial begin
        tick(3);
        cmp(first_power_good_n, 1'h1);
        cmp(enable_pin_state, 1'h1);
        cmp4(retry_en, 4'h7);
        sys_rst = 1'h0;
        tick(2);
        on_pin = 1'h1;
        note(0, 1'h1, 0, B + 8);
        wait_gate(1'h1);
        chain(1'h0);
        cmp(fet_on_ctrl, 1'h1);
        r = 4'($random(seed));
        wr_retry = 1'h1;
        wr_retry_value = r;
        tick(1);
        cmp4(retry_en, r);
        wr_retry_value = 4'h7;
        tick(1);
        wr_retry = 1'h0;
        $display("test startup done");
        wr_fet_on_ctrl = 1'h1;
        off(0, 4, 1'h1);
        tick(1);
        wr_fet_on_ctrl = 1'h0;
        tick(3);
        cmp(fet_on_ctrl, 1'h0);
        enable_pin_n = 1'h1;
        tick(3);
        cmp(enable_pin_state, 1'h1);
        cmp(enable_change_fault, 1'h1);
        tick(1 + ($random(seed) & 7));
        enable_pin_n = 1'h0;
        tick(6);
        cmp(enable_pin_state, 1'h0);
        cmp(fet_on_ctrl, 1'h1);
        note(0, 1'h1, 0, B + 8);
        wait_gate(1'h1);
        chain(1'h0);
        $display("test enable done");
        high_supply_in = 1'h1;
        off(0, 4, 1'h0);
        tick(4);
        cmp(overvoltage_present, 1'h1);
        cmp(overvoltage_fault, 1'h1);
        high_supply_in = 1'h0;
        note(0, 1'h1, 0, 4);
        tick(8);
        vin_lockout = 1'h1;
        off(0, 4, 1'h1);
        uv_ok = 1'h0;
        tick(5);
        cmp(undervoltage_fault, 1'h1);
        vin_lockout = 1'h0;
        uv_ok = 1'h1;
        note(0, 1'h1, 0, B + 8);
        wait_gate(1'h1);
        chain(1'h0);
        $display("test overvoltage and lockout done");
        sense_over_limit = 1'h1;
        off(BR, BR + 5, 1'h1);
        wait_gate(1'h0);
        sense_over_limit = 1'h0;
        note(0, 1'h1, 4 * B - 8, 4 * B + 6);
        cmp(overcurrent_fault, 1'h1);
        tick(5);
        high_supply_in = 1'h1;
        tick(2);
        high_supply_in = 1'h0;
        good = 1'h0;
        wait_gate(1'h1);
        chain(1'h1);
        cmp(power_bad_fault, 1'h1);
        tick(2 * B);
        good = 1'h1;
        wr_fault_clear = 1'h1;
        wr_fault_clear_mask = 4'h8;
        note(0, 1'h1, B - 3, B + 8);
        tick(1);
        wr_fault_clear = 1'h0;
        wait_gate(1'h1);
        chain(1'h0);
        $display("test overcurrent and power-bad done");
        sense_fast_trip = 1'h1;
        note(0, 1'h0, 0, 3);
        tick(2);
        cmp(fast_pulldown, 1'h1);
        sense_fast_trip = 1'h0;
        note(0, 1'h1, 0, 3);
        tick(3);
        int_lock = 1'h1;
        off(0, 4, 1'h1);
        tick(4);
        cmp(fet_on_ctrl, 1'h0);
        cmp(enable_change_fault, 1'h0);
        $display("test fast trip and lockout done");
        complete_run();
    end
endmodule // hot_swap_fault_sequencer_tb
`default_nettype wire
